//--- common/tcc_cfg.svh
// Purpose: register offsets, field positions and reset values of the
//          timer clock-and-clear control block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   offsets of the sync, mode and counter registers are local
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// register byte offsets (control registers step by one word)
`define TCC_OFF_CTRL0 8'h00
`define TCC_OFF_SYNC 8'h14
`define TCC_OFF_MODE 8'h18
`define TCC_OFF_CNT0 8'h20
`define TCC_IDX_CTRL0 6'h00
`define TCC_IDX_CNT0 6'h08

// fields of the clock-and-clear control register
`define TCC_RSV_BIT 7
`define TCC_CLR_HI 6
`define TCC_CLR_LO 5
`define TCC_EDG_HI 4
`define TCC_EDG_LO 3
`define TCC_SRC_HI 2
`define TCC_SRC_LO 0

// reset values
`define TCC_CTRL_RST 7'h00
`define TCC_CNT_RST 16'h0000
`define TCC_PRESC_RST 8'h00

// channel that owns phase counting, and its flag position in the mode reg
`define TCC_PHASE_CH 2
`define TCC_MODE_PHASE_BIT 0

`endif

//--- common/tcc_pkg.sv
// Purpose: shared types of the timer clock-and-clear control block
// Assumes: field encodings follow the control register layout
// Notes:   enum order matches the field codes
package tcc_pkg;

	// counter clear source, two-bit field
	typedef enum logic [1:0] {
		TCC_CLR_NONE,
		TCC_CLR_A,
		TCC_CLR_B,
		TCC_CLR_SYNC
	} tcc_clr_type;

	// external edge selection, two-bit field
	typedef enum logic [1:0] {
		TCC_EDGE_RISE,
		TCC_EDGE_FALL,
		TCC_EDGE_BOTH0,
		TCC_EDGE_BOTH1
	} tcc_edge_type;

endpackage

//--- src/tcc_channel.sv
// Purpose: one timer channel, clock select, clear select and counter
// Assumes: all event and tick inputs are one-cycle pulses on pclk
// Notes:   clear has priority over a count in the same cycle
`include "tcc_cfg.svh"

module tcc_channel
	import tcc_pkg::*;
#(
	parameter int CW = 16
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic standby,
	// control fields
	input wire logic [6:0] ctrl,
	input wire logic phase_mode,
	input wire logic sync_en,
	// count sources
	input wire logic [3:0] int_tick,
	input wire logic [3:0] ext_rise,
	input wire logic [3:0] ext_fall,
	input wire logic phase_pulse,
	// general register events
	input wire logic gra_is_capture,
	input wire logic gra_compare,
	input wire logic gra_capture,
	input wire logic grb_is_capture,
	input wire logic grb_compare,
	input wire logic grb_capture,
	// synchronous clear
	input wire logic sync_clr_in,
	output logic clear_out,
	// counter
	output logic [CW-1:0] counter_r
);

	logic [CW-1:0] counter_nxt;
	tcc_clr_type clr_mode;
	tcc_edge_type edge_mode;
	wire logic [2:0] src = ctrl[`TCC_SRC_HI:`TCC_SRC_LO];
	wire logic [1:0] sel = src[1:0];

	// field decode
	assign clr_mode = tcc_clr_type'(ctrl[`TCC_CLR_HI:`TCC_CLR_LO]);
	assign edge_mode = tcc_edge_type'(ctrl[`TCC_EDG_HI:`TCC_EDG_LO]);

	// external edge pick; upper edge bit alone means both edges
	wire logic ext_pulse = edge_mode[1] ? (ext_rise[sel] | ext_fall[sel]) :
		(edge_mode[0] ? ext_fall[sel] : ext_rise[sel]);
	// internal ticks already mark falling edges of the divided clock
	wire logic src_pulse = src[2] ? ext_pulse : int_tick[sel];
	// phase counting overrides both edge and source fields
	wire logic count_pulse = phase_mode ? phase_pulse : src_pulse;

	// event kind follows the register's function
	wire logic gra_evt = gra_is_capture ? gra_capture : gra_compare;
	wire logic grb_evt = grb_is_capture ? grb_capture : grb_compare;

	// own clears drive the shared line; sync clears do not, avoiding loops
	wire logic own_clear = (clr_mode == TCC_CLR_A && gra_evt) ||
		(clr_mode == TCC_CLR_B && grb_evt);
	wire logic sync_clear = clr_mode == TCC_CLR_SYNC && sync_en &&
		sync_clr_in;
	assign clear_out = own_clear;

	// counter next value, clear wins over count
	assign counter_nxt = (own_clear || sync_clear) ? `TCC_CNT_RST :
		(count_pulse ? counter_r + CW'(1) : counter_r);

	// counter register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			counter_r <= `TCC_CNT_RST;
		end else if (standby) begin
			counter_r <= `TCC_CNT_RST;
		end else begin
			counter_r <= counter_nxt;
		end
	end

	chk_clear_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!standby && clr_mode == TCC_CLR_A && gra_evt
		|=> counter_r == `TCC_CNT_RST)
		else $error("counter not cleared by register A event");

	chk_clear_b: assert property (
		@(posedge pclk) disable iff (!presetn)
		!standby && clr_mode == TCC_CLR_B && grb_evt
		|=> counter_r == `TCC_CNT_RST)
		else $error("counter not cleared by register B event");

	chk_sync_follow: assert property (
		@(posedge pclk) disable iff (!presetn)
		!standby && clr_mode == TCC_CLR_SYNC && sync_en && sync_clr_in
		|=> counter_r == `TCC_CNT_RST)
		else $error("counter missed a synchronous clear");

	chk_step_one: assert property (
		@(posedge pclk) disable iff (!presetn)
		!standby && !own_clear && !sync_clear
		|=> counter_r == $past(counter_r) + CW'($past(count_pulse)))
		else $error("counter moved by other than one count");

	chk_no_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		!standby && clr_mode == TCC_CLR_NONE |-> !clear_out)
		else $error("clear raised with clearing disabled");

endmodule

//--- src/tcc_top.sv
// Purpose: clock-and-clear control for a five-channel 16-bit timer,
//          with an APB register slave
// Assumes: event and pin inputs synchronous to pclk except ext clocks
// Notes:   zero-wait APB; read data captured during the setup cycle
`include "tcc_cfg.svh"

module tcc_top
	import tcc_pkg::*;
#(
	parameter int NCH = 5,
	parameter int CW = 16,
	parameter int DIV_C = 4,
	parameter int DIV_D = 8,
	parameter logic RSV_READ = 1'b1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic standby,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// external clock pins
	input wire logic ext_clock_in_a,
	input wire logic ext_clock_in_b,
	input wire logic ext_clock_in_c,
	input wire logic ext_clock_in_d,
	// phase counting count pulse for the phase channel
	input wire logic phase_count_pulse,
	// general register functions and events, one bit per channel
	input wire logic [NCH-1:0] gra_is_capture,
	input wire logic [NCH-1:0] gra_compare,
	input wire logic [NCH-1:0] gra_capture,
	input wire logic [NCH-1:0] grb_is_capture,
	input wire logic [NCH-1:0] grb_compare,
	input wire logic [NCH-1:0] grb_capture,
	// counter values and shared clear pulses
	output logic [NCH*CW-1:0] channel_counter,
	output logic [NCH-1:0] sync_clear_out
);

	localparam int LOG_C = $clog2(DIV_C);
	localparam int LOG_D = $clog2(DIV_D);

	logic [6:0] ctrl_r [NCH];
	logic [NCH-1:0] channel_sync_register_r;
	logic phase_count_mode_flag_r;
	logic [7:0] presc_r;
	logic [31:0] prdata_r;
	logic [3:0] ext_s1_r;
	logic [3:0] ext_s2_r;
	logic [3:0] ext_s3_r;
	logic [3:0] ext_rise;
	logic [3:0] ext_fall;
	logic [3:0] int_tick;
	logic [NCH-1:0] clear_out;
	logic [CW-1:0] cnt_w [NCH];
	logic [31:0] rd_val;

	// apb decode; word index from the byte address
	wire logic [5:0] idx = paddr[7:2];
	wire logic setup = psel && !penable;
	wire logic access = psel && penable;
	wire logic hit_ctrl = idx >= `TCC_IDX_CTRL0 &&
		idx < `TCC_IDX_CTRL0 + 6'(NCH);
	wire logic hit_cnt = idx >= `TCC_IDX_CNT0 &&
		idx < `TCC_IDX_CNT0 + 6'(NCH);
	wire logic hit_sync = paddr == `TCC_OFF_SYNC;
	wire logic hit_mode = paddr == `TCC_OFF_MODE;
	wire logic mapped = hit_ctrl || hit_cnt || hit_sync || hit_mode;
	wire logic wr_en = access && pwrite && pstrb[0];
	wire logic [2:0] ctrl_sel = 3'(idx - `TCC_IDX_CTRL0);
	wire logic [2:0] cnt_sel = 3'(idx - `TCC_IDX_CNT0);

	// zero-wait slave; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign prdata = prdata_r;

	// read mux; bit 7 of control reads a fixed value
	assign rd_val = hit_ctrl ? {24'h000000, RSV_READ, ctrl_r[ctrl_sel]} :
		hit_cnt ? 32'(cnt_w[cnt_sel]) :
		hit_sync ? 32'(channel_sync_register_r) :
		hit_mode ? 32'(phase_count_mode_flag_r) : 32'h00000000;

	// read data captured in the setup cycle so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
		end else if (setup && !pwrite) begin
			prdata_r <= rd_val;
		end
	end

	// control registers, one per channel, all fields alike
	generate
		for (genvar i = 0; i < NCH; i++) begin : g_ctrl
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					ctrl_r[i] <= `TCC_CTRL_RST;
				end else if (standby) begin
					ctrl_r[i] <= `TCC_CTRL_RST;
				end else if (wr_en && hit_ctrl && ctrl_sel == 3'(i)) begin
					ctrl_r[i] <= pwdata[6:0];
				end
			end
		end
	endgenerate

	// sync selection and phase mode flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			channel_sync_register_r <= '0;
			phase_count_mode_flag_r <= 1'b0;
		end else if (standby) begin
			channel_sync_register_r <= '0;
			phase_count_mode_flag_r <= 1'b0;
		end else if (wr_en && hit_sync) begin
			channel_sync_register_r <= pwdata[NCH-1:0];
		end else if (wr_en && hit_mode) begin
			phase_count_mode_flag_r <= pwdata[`TCC_MODE_PHASE_BIT];
		end
	end

	// free-running prescaler; power-of-two divisors only, so one counter
	// serves every division and the ticks stay phase aligned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_r <= `TCC_PRESC_RST;
		end else begin
			presc_r <= presc_r + 8'h01;
		end
	end

	// a tick marks the falling edge of each divided clock
	assign int_tick[0] = 1'b1;
	assign int_tick[1] = presc_r[0];
	assign int_tick[2] = &presc_r[LOG_C-1:0];
	assign int_tick[3] = &presc_r[LOG_D-1:0];

	// external pins: two-flop synchroniser, third flop for edge detect
	wire logic [3:0] ext_pin = {ext_clock_in_d, ext_clock_in_c,
		ext_clock_in_b, ext_clock_in_a};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_r <= 4'h0;
			ext_s2_r <= 4'h0;
			ext_s3_r <= 4'h0;
		end else begin
			ext_s1_r <= ext_pin;
			ext_s2_r <= ext_s1_r;
			ext_s3_r <= ext_s2_r;
		end
	end
	assign ext_rise = ext_s2_r & ~ext_s3_r;
	assign ext_fall = ~ext_s2_r & ext_s3_r;

	// channels; sync input is the OR of other synchronized own clears
	wire logic [NCH-1:0] shared_clr = clear_out & channel_sync_register_r;
	assign sync_clear_out = clear_out;
	generate
		for (genvar i = 0; i < NCH; i++) begin : g_ch
			wire logic others = |(shared_clr &
				~(NCH'(1) << i));
			tcc_channel #(
				.CW(CW)
			) u_ch (
				.pclk(pclk),
				.presetn(presetn),
				.standby(standby),
				.ctrl(ctrl_r[i]),
				.phase_mode(phase_count_mode_flag_r &&
					i == `TCC_PHASE_CH),
				.sync_en(channel_sync_register_r[i]),
				.int_tick(int_tick),
				.ext_rise(ext_rise),
				.ext_fall(ext_fall),
				.phase_pulse(phase_count_pulse),
				.gra_is_capture(gra_is_capture[i]),
				.gra_compare(gra_compare[i]),
				.gra_capture(gra_capture[i]),
				.grb_is_capture(grb_is_capture[i]),
				.grb_compare(grb_compare[i]),
				.grb_capture(grb_capture[i]),
				.sync_clr_in(others),
				.clear_out(clear_out[i]),
				.counter_r(cnt_w[i])
			);
			assign channel_counter[i*CW +: CW] = cnt_w[i];
		end
	endgenerate

	chk_standby_init: assert property (
		@(posedge pclk) disable iff (!presetn)
		standby |=> ctrl_r[0] == `TCC_CTRL_RST &&
		ctrl_r[NCH-1] == `TCC_CTRL_RST)
		else $error("control not initialised by standby");

	chk_ctrl_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		!standby && wr_en && hit_ctrl && ctrl_sel == 3'(1)
		|=> ctrl_r[1] == $past(pwdata[6:0]))
		else $error("control write did not land");

	chk_rsv_read: assert property (
		@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && hit_ctrl
		|=> prdata[`TCC_RSV_BIT] == RSV_READ && prdata[31:8] == 24'h000000)
		else $error("reserved bit read back wrongly");

	chk_edge_pulse: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(ext_rise[0] && ext_fall[0]) and (ext_rise[0] |=> !ext_rise[0]))
		else $error("external edge pulse not single");

	chk_tick_rate: assert property (
		@(posedge pclk) disable iff (!presetn)
		int_tick[1] |=> !int_tick[1] ##1 int_tick[1])
		else $error("half-rate tick not alternating");

endmodule

//--- tb/testbench.sv
// Purpose: self-checking bench of the timer clock-and-clear control block
// Assumes: default parameters, zero-wait apb, pins driven on pclk edges
// Notes:   rates are judged as count differences, so tick phase is free
module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic standby = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] pins = 4'h0;
	logic phase_p = 1'b0;
	logic [4:0] is_cap = 5'h00;
	logic [4:0] ev_r [4] = '{default: 5'h00};
	logic [79:0] cc;
	logic [4:0] sco;
	logic [31:0] rdat;
	logic rerr;
	int n_errors = 0;
	int n_tests = 0;

	// 40 MHz clock
	always #12.5 pclk = ~pclk;

	tcc_top uut (
		.pclk(pclk), .presetn(presetn), .standby(standby),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_clock_in_a(pins[0]),
		.ext_clock_in_b(pins[1]), .ext_clock_in_c(pins[2]),
		.ext_clock_in_d(pins[3]), .phase_count_pulse(phase_p),
		.gra_is_capture(is_cap), .gra_compare(ev_r[0]),
		.gra_capture(ev_r[1]), .grb_is_capture(is_cap),
		.grb_compare(ev_r[2]), .grb_capture(ev_r[3]),
		.channel_counter(cc), .sync_clear_out(sco)
	);

	task final_report;
		if (n_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	function automatic logic [15:0] cnt(input int ch);
		return cc[16*ch +: 16];
	endfunction

	// one apb transfer; entered and left just after a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			n++;
			@(posedge pclk);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge, so a following call never re-drives psel at once
		@(posedge pclk);
		if (n >= 20) begin
			n_errors++;
			final_report();
		end
	endtask

	// rate of one internal source on channel 1
	task t_rate(input logic [2:0] code, input int div);
		logic [15:0] c0;
		apb(1'b1, 8'h04, {29'h0, code});
		repeat (4) @(posedge pclk);
		c0 = cnt(1);
		repeat (32) @(posedge pclk);
		chk("int rate", 32 / div, cnt(1) - c0);
	endtask

	// four pin pulses counted on channel 3 with one edge mode
	task t_ext(input int pin, input logic [1:0] edg, input int exp);
		logic [15:0] c0;
		apb(1'b1, 8'h0C, {27'h0, edg, 1'b1, 2'(pin)});
		repeat (4) @(posedge pclk);
		c0 = cnt(3);
		repeat (4) begin
			pins[pin] <= 1'b1;
			repeat (4) @(posedge pclk);
			pins[pin] <= 1'b0;
			repeat (4) @(posedge pclk);
		end
		repeat (6) @(posedge pclk);
		chk("ext count", exp, cnt(3) - c0);
	endtask

	// one register event against one clear setting
	task t_clr(input int ch, input logic [7:0] ctl, input logic cap,
		input int ev, input logic exp);
		apb(1'b1, 8'(4 * ch), {24'h0, ctl});
		is_cap[ch] <= cap;
		repeat (5) @(posedge pclk);
		ev_r[ev][ch] <= 1'b1;
		@(negedge pclk);
		chk("clear out", exp, sco[ch]);
		@(posedge pclk);
		ev_r[ev][ch] <= 1'b0;
		#1;
		chk("cleared", exp, cnt(ch) == 16'h0);
		@(posedge pclk);
	endtask

	task t_sync;
		apb(1'b1, 8'h14, 32'h11);
		apb(1'b1, 8'h10, 32'h60);
		apb(1'b1, 8'h04, 32'h60);
		apb(1'b1, 8'h00, 32'h20);
		is_cap[0] <= 1'b0;
		repeat (5) @(posedge pclk);
		ev_r[0][0] <= 1'b1;
		@(posedge pclk);
		ev_r[0][0] <= 1'b0;
		#1;
		chk("sync member", 1'b1, cnt(4) == 16'h0);
		chk("sync outsider", 1'b0, cnt(1) == 16'h0);
		@(posedge pclk);
	endtask

	task t_phase;
		logic [15:0] c0;
		apb(1'b1, 8'h18, 32'h1);
		apb(1'b1, 8'h08, 32'h00);
		repeat (3) @(posedge pclk);
		c0 = cnt(2);
		repeat (10) @(posedge pclk);
		chk("phase idle", c0, cnt(2));
		repeat (3) begin
			phase_p <= 1'b1;
			@(posedge pclk);
			phase_p <= 1'b0;
			@(posedge pclk);
		end
		@(posedge pclk);
		chk("phase count", c0 + 16'h3, cnt(2));
		apb(1'b1, 8'h18, 32'h0);
	endtask

	task t_regs;
		for (int i = 0; i < 5; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk("ctrl reset", 32'h80, rdat);
			apb(1'b1, 8'(4 * i), 32'h58 + i);
			apb(1'b0, 8'(4 * i), 32'h0);
			chk("ctrl rw", 32'hD8 + i, rdat);
		end
		apb(1'b1, 8'h08, 32'hFF);
		apb(1'b0, 8'h08, 32'h0);
		chk("ctrl bit7", 32'hFF, rdat);
		apb(1'b0, 8'hFC, 32'h0);
		chk("unmapped err", 1'b1, rerr);
		standby <= 1'b1;
		repeat (2) @(posedge pclk);
		standby <= 1'b0;
		@(posedge pclk);
		apb(1'b0, 8'h08, 32'h0);
		chk("standby init", 32'h80, rdat);
	endtask

	// main sequence
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_rate(3'h0, 1);
		t_rate(3'h1, 2);
		t_rate(3'h2, 4);
		t_rate(3'h3, 8);
		for (int p = 0; p < 4; p++) begin
			t_ext(p, 2'h0, 4);
		end
		t_ext(1, 2'h1, 4);
		t_ext(2, 2'h2, 8);
		t_ext(3, 2'h3, 8);
		t_clr(0, 8'h20, 1'b0, 0, 1'b1);
		t_clr(0, 8'h20, 1'b0, 1, 1'b0);
		t_clr(0, 8'h20, 1'b1, 1, 1'b1);
		t_clr(0, 8'h20, 1'b0, 2, 1'b0);
		t_clr(1, 8'h40, 1'b0, 2, 1'b1);
		t_clr(1, 8'h40, 1'b1, 3, 1'b1);
		t_clr(1, 8'h00, 1'b0, 0, 1'b0);
		t_sync();
		t_phase();
		final_report();
	end
endmodule
